/* rtl/tsa_pkg.sv */
// Shared constants, types and encodings of the temperature alarm sensor
package tsa_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TIME_MS = 130;
  localparam int CONV_CYCLES = CONV_TIME_MS * (1000000 / CLK_PERIOD_NS);
  // Slave address: upper five bits fixed, low two from the select pin
  localparam logic [4:0] DEV_ADDR_HI = 5'h12;
  // Pointer codes
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_TLOW = 2'h2;
  localparam logic [1:0] PTR_THIGH = 2'h3;
  // Reset values
  localparam logic [15:0] TEMP_INVALID = 16'h8000;
  localparam logic [8:0] THIGH_RST = 9'h0a0;
  localparam logic [8:0] TLOW_RST = 9'h096;
  // Configuration field positions
  localparam int CFG_SHDN = 0;
  localparam int CFG_INTM = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_W = 5;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
  // Side event registers
  localparam logic [1:0] EVT_STATUS_OFS = 2'h0;
  localparam logic [1:0] EVT_MASK_OFS = 2'h1;
  localparam int EVT_CONV = 0;
  localparam int EVT_ALARM_ON = 1;
  localparam int EVT_ALARM_OFF = 2;
  localparam int EVT_BUS_WR = 3;
  localparam int EVT_W = 4;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;

  typedef struct packed {
    logic [1:0] fault_depth;
    logic pol_high;
    logic int_mode;
    logic shutdown;
  } tsa_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RX = 3'b010,
    ST_ACK = 3'b011,
    ST_TX = 3'b100,
    ST_MACK = 3'b101
  } tsa_state_t;
endpackage

/* rtl/tsa_glitch_filt.sv */
// Two-stage synchroniser followed by a spike suppressor
module tsa_glitch_filt
  import tsa_pkg::*;
#(
  parameter int STABLE_CYCLES = SPIKE_CYCLES,
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level_q
);
  logic meta_q;
  logic sync_q;
  logic [7:0] cnt_q;

  // Two flip-flops before any logic looks at the pin
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // Output follows only after the new level held for the whole window
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= 8'h00;
      level_q <= RESET_VAL;
    end else if (sync_q == level_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= 8'(STABLE_CYCLES - 1)) begin
      cnt_q <= 8'h00;
      level_q <= sync_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* rtl/tsa_conv.sv */
// Conversion timer and result register
module tsa_conv
  import tsa_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES,
  parameter int RES_BITS = 9
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic shutdown,
  // Converter code, full scale signed, left-justified
  input wire logic [11:0] adc_code,
  // Result
  output logic [15:0] result_q,
  output logic done_q
);
  localparam logic [15:0] RES_MASK = ~(16'hffff >> RES_BITS);
  logic [31:0] cnt_q;

  // Free-running cycle timer, restarted whenever conversion is halted
  always_ff @(posedge ref_clk) begin
    if (srst || !run || shutdown) begin
      cnt_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end else if (cnt_q >= 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0000_0000;
      done_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      done_q <= 1'b0;
    end
  end

  // Result holds the invalid code until a conversion completes
  always_ff @(posedge ref_clk) begin
    if (srst || shutdown) begin
      result_q <= TEMP_INVALID;
    end else if (run && cnt_q >= 32'(CYCLES - 1)) begin
      result_q <= {adc_code, 4'h0} & RES_MASK;
    end
  end
endmodule

/* rtl/tsa_top.sv */
// Temperature sensor digital core: serial slave, registers, alarm
//
// Overview of operation
// - Converts continuously except while a temperature read is pending; latest result readable over the bus any time.
// - Alarm asserts when result exceeds high threshold, after fault qualify.
// - Fault queue depth of conversions must agree before alarm changes.
// - Alarm pin polarity chosen by a configuration bit.
// - Comparator mode: alarm clears only below low threshold, qualified.
// - Interrupt mode: any register read clears an active alarm.
// - One conversion about every 130 ms, result updated once per cycle.
// - Result reads 8000h after power-up until first conversion completes.
// - Shutdown bit stops conversion; bus and reset logic keep running.
// - Result forced to 8000h while shut down.
// - Slave only: byte and word reads and writes.
// - Address pin tied low, high, to data or clock gives 0..3.
// - Data, clock and address inputs ignore spikes under 50 ns.
// - Pointer written first; bits 1:0 pick register, others read zero.
// - Config bits: shutdown, interrupt mode, active-high; reset zero.
// - Config bits 4:3 give fault depth 1, 2, 4 or 6.
// - Temperature left-justified two's complement, unused low bits zero.
//
// Local design decisions: the address-and-strobe port and the address map.
module tsa_top
  import tsa_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES,
  parameter int RES_BITS = 9
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic add_in,
  // Alarm pin
  output logic overtemp_alarm_out,
  // Converter code
  input wire logic [11:0] adc_code,
  // Event register port
  input wire logic [1:0] evt_addr,
  input wire logic [7:0] evt_wdata,
  input wire logic evt_wr,
  input wire logic evt_rd,
  output logic [7:0] evt_rdata,
  output logic evt_irq
);
  // Fault count needed for a given depth code
  function automatic logic [2:0] fault_need(input logic [1:0] code);
    unique case (code)
      2'h0: fault_need = 3'h1;
      2'h1: fault_need = 3'h2;
      2'h2: fault_need = 3'h4;
      2'h3: fault_need = 3'h6;
    endcase
  endfunction

  logic scl_f, sda_f, add_f;
  logic scl_d1_q, sda_d1_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  tsa_state_t state_q;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic done_q;
  logic rw_q;
  logic [1:0] byte_q;
  logic [1:0] ptr_q;
  logic [7:0] msb_q;
  logic [15:0] tx_q;
  logic sda_oe_q;
  logic hold_q;
  logic [7:0] rx_byte;
  logic seen_low_q, diff_scl_q, diff_sda_q;
  logic [1:0] add_sel;
  tsa_cfg_t cfg_q;
  logic [8:0] thigh_q, tlow_q;
  logic [15:0] temp;
  logic conv_done;
  logic hot_q, int_alarm_q, alarm_pin_q;
  logic [2:0] fault_q;
  logic cond, flip, reg_read, reg_write;
  logic [EVT_W-1:0] evt_stat_q, evt_mask_q, evt_set;
  logic [7:0] evt_rdata_q;

  // Spike filters on all three pins
  tsa_glitch_filt #(.STABLE_CYCLES(SPIKE_CYCLES), .RESET_VAL(1'b1)) u_scl (
    .ref_clk(ref_clk), .srst(srst), .pin_in(scl_in), .level_q(scl_f));
  tsa_glitch_filt #(.STABLE_CYCLES(SPIKE_CYCLES), .RESET_VAL(1'b1)) u_sda (
    .ref_clk(ref_clk), .srst(srst), .pin_in(sda_in), .level_q(sda_f));
  tsa_glitch_filt #(.STABLE_CYCLES(SPIKE_CYCLES), .RESET_VAL(1'b1)) u_add (
    .ref_clk(ref_clk), .srst(srst), .pin_in(add_in), .level_q(add_f));

  // Converter, halted by shutdown or a pending temperature read
  tsa_conv #(.CYCLES(CONV_CYC), .RES_BITS(RES_BITS)) u_conv (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(!hold_q),
    .shutdown(cfg_q.shutdown),
    .adc_code(adc_code),
    .result_q(temp),
    .done_q(conv_done)
  );

  // Bus edge and condition detection on filtered levels
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_f;
      sda_d1_q <= sda_f;
    end
  end
  assign scl_rise = scl_f && !scl_d1_q;
  assign scl_fall = !scl_f && scl_d1_q;
  assign bus_start = scl_f && scl_d1_q && sda_d1_q && !sda_f;
  assign bus_stop = scl_f && scl_d1_q && !sda_d1_q && sda_f;
  assign rx_byte = {shift_q[6:0], sda_f};

  // Address pin strap: watch whether it ever differs from each line
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seen_low_q <= 1'b0;
      diff_scl_q <= 1'b0;
      diff_sda_q <= 1'b0;
    end else begin
      if (!add_f) seen_low_q <= 1'b1;
      if (add_f != scl_f) diff_scl_q <= 1'b1;
      if (add_f != sda_f) diff_sda_q <= 1'b1;
    end
  end
  always_comb begin
    if (!seen_low_q) add_sel = 2'h1;
    else if (!diff_scl_q) add_sel = 2'h3;
    else if (!diff_sda_q) add_sel = 2'h2;
    else add_sel = 2'h0;
  end

  // Register access strobes
  assign reg_read = (state_q == ST_ADDR) && scl_rise && done_q == 1'b0 &&
                    bit_q == 3'h7 && rx_byte[7:1] == {DEV_ADDR_HI, add_sel} &&
                    rx_byte[0];
  assign reg_write = (state_q == ST_RX) && scl_rise && bit_q == 3'h7 &&
                     byte_q != 2'h0;

  // Serial slave state machine
  always_ff @(posedge ref_clk) begin
    if (srst || bus_stop) begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      done_q <= 1'b0;
      byte_q <= 2'h0;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= ST_ADDR;
      bit_q <= 3'h0;
      done_q <= 1'b0;
      byte_q <= 2'h0;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_q)
        ST_ADDR, ST_RX, ST_TX: begin
          shift_q <= rx_byte;
          bit_q <= bit_q + 3'h1;
          done_q <= (bit_q == 3'h7);
          if (state_q == ST_ADDR && bit_q == 3'h7) begin
            if (rx_byte[7:1] == {DEV_ADDR_HI, add_sel}) begin
              rw_q <= rx_byte[0];
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_MACK: begin
          if (sda_f) state_q <= ST_IDLE; // Master NACK ends the read
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        ST_ADDR, ST_RX: begin
          if (done_q) begin
            state_q <= ST_ACK;
            sda_oe_q <= 1'b1;
            done_q <= 1'b0;
            if (state_q == ST_RX && byte_q != 2'h3) byte_q <= byte_q + 2'h1;
          end
        end
        ST_ACK: begin
          if (rw_q) begin
            state_q <= ST_TX;
            sda_oe_q <= !tx_q[15];
          end else begin
            state_q <= ST_RX;
            sda_oe_q <= 1'b0;
          end
        end
        ST_TX: begin
          tx_q <= {tx_q[14:0], 1'b0};
          if (done_q) begin
            state_q <= ST_MACK;
            sda_oe_q <= 1'b0;
            done_q <= 1'b0;
          end else begin
            sda_oe_q <= !tx_q[14];
          end
        end
        ST_MACK: begin
          state_q <= ST_TX;
          sda_oe_q <= !tx_q[15];
        end
        default: begin
        end
      endcase
    end
    // Snapshot of the selected register for the read that follows
    if (!srst && reg_read) begin
      unique case (ptr_q)
        PTR_TEMP: tx_q <= temp;
        PTR_CFG: tx_q <= {3'h0, cfg_q, 3'h0, cfg_q};
        PTR_TLOW: tx_q <= {tlow_q, 7'h00};
        PTR_THIGH: tx_q <= {thigh_q, 7'h00};
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;

  // Pointer and writable registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ptr_q <= PTR_TEMP;
      msb_q <= 8'h00;
      cfg_q <= CFG_RST;
      thigh_q <= THIGH_RST;
      tlow_q <= TLOW_RST;
    end else if (state_q == ST_RX && scl_rise && bit_q == 3'h7) begin
      if (byte_q == 2'h0) begin
        ptr_q <= rx_byte[1:0];
      end else if (byte_q == 2'h1) begin
        msb_q <= rx_byte;
        if (ptr_q == PTR_CFG) cfg_q <= rx_byte[CFG_W-1:0];
      end else begin
        if (ptr_q == PTR_TLOW) tlow_q <= {msb_q, rx_byte[7]};
        if (ptr_q == PTR_THIGH) thigh_q <= {msb_q, rx_byte[7]};
      end
    end
  end

  // A temperature read freezes conversion until the stop condition
  always_ff @(posedge ref_clk) begin
    if (srst || bus_stop) begin
      hold_q <= 1'b0;
    end else if (reg_read && ptr_q == PTR_TEMP) begin
      hold_q <= 1'b1;
    end
  end

  // Fault queue and comparator state
  assign cond = hot_q ? ($signed(temp[15:7]) < $signed(tlow_q))
                      : ($signed(temp[15:7]) > $signed(thigh_q));
  assign flip = conv_done && cond &&
                (fault_q + 3'h1 >= fault_need(cfg_q.fault_depth));
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_q <= 3'h0;
      hot_q <= 1'b0;
    end else if (conv_done) begin
      if (flip) begin
        fault_q <= 3'h0;
        hot_q <= !hot_q;
      end else if (cond) begin
        fault_q <= fault_q + 3'h1;
      end else begin
        fault_q <= 3'h0;
      end
    end
  end

  // Interrupt-mode latch: set on trip, cleared by a register read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      int_alarm_q <= 1'b0;
    end else if (flip && !hot_q) begin
      int_alarm_q <= 1'b1; // Set wins over a same-cycle read
    end else if (reg_read || reg_write) begin
      int_alarm_q <= 1'b0;
    end
  end

  // Alarm pin with selectable mode and polarity
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alarm_pin_q <= 1'b1;
    end else begin
      alarm_pin_q <= (cfg_q.int_mode ? int_alarm_q : hot_q)
                     ~^ cfg_q.pol_high;
    end
  end
  assign overtemp_alarm_out = alarm_pin_q;

  // Sticky event status, mask and interrupt line
  assign evt_set = {reg_write, flip && hot_q, flip && !hot_q, conv_done};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_stat_q <= EVT_RST;
      evt_mask_q <= EVT_RST;
      evt_rdata_q <= 8'h00;
    end else begin
      if (evt_wr && evt_addr == EVT_STATUS_OFS) begin
        evt_stat_q <= (evt_stat_q & ~evt_wdata[EVT_W-1:0]) | evt_set;
      end else begin
        evt_stat_q <= evt_stat_q | evt_set;
      end
      if (evt_wr && evt_addr == EVT_MASK_OFS) begin
        evt_mask_q <= evt_wdata[EVT_W-1:0];
      end
      if (evt_rd) begin
        unique case (evt_addr)
          EVT_STATUS_OFS: evt_rdata_q <= {4'h0, evt_stat_q};
          EVT_MASK_OFS: evt_rdata_q <= {4'h0, evt_mask_q};
          default: evt_rdata_q <= 8'h00;
        endcase
      end
    end
  end
  assign evt_rdata = evt_rdata_q;
  assign evt_irq = |(evt_stat_q & evt_mask_q);
endmodule

/* verification/tsa_top_sva.sv */
// Port-level assertions for the temperature alarm sensor core
module tsa_top_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Alarm pin and event port
  input wire logic overtemp_alarm_out,
  input wire logic evt_rd,
  input wire logic [7:0] evt_rdata,
  input wire logic evt_irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // Idle levels seen on the first edge after reset
  rst_pins_a: assert property ($fell(srst) |->
    !sda_oe && overtemp_alarm_out)
    else $error("pins not idle after reset");
  rst_evt_a: assert property ($fell(srst) |-> !evt_irq && evt_rdata == 8'h00)
    else $error("event port not idle after reset");
  // Open drain: the device only ever pulls low
  sda_low_a: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data pin driven high");
  // Data changes only while the bus clock is low
  oe_rise_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while clock high");
  oe_fall_a: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
  oe_hold_a: assert property ($rose(scl_in) |=> $stable(sda_oe) [*8])
    else $error("data moved during clock high");
  // Read data stands until the next read strobe
  rdata_hold_a: assert property (!evt_rd |=> $stable(evt_rdata))
    else $error("read data changed without read");
  rdata_top_a: assert property (evt_rdata[7:4] == 4'h0)
    else $error("unused read bits set");

  c_ack_c: cover property ($rose(sda_oe));
  c_alarm_c: cover property ($changed(overtemp_alarm_out));
  c_irq_c: cover property ($rose(evt_irq));
endmodule

bind tsa_top tsa_top_sva chk_u (
  .ref_clk(ref_clk),
  .srst(srst),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .overtemp_alarm_out(overtemp_alarm_out),
  .evt_rd(evt_rd),
  .evt_rdata(evt_rdata),
  .evt_irq(evt_irq)
);

/* verification/tsa_bus_master.sv */
// Behavioural serial bus master that drives clock and pulls data
module tsa_bus_master (
  // Bus pins
  output logic scl,
  output logic m_oe,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quarter bit: clock low and high phases last 160 ns each
  localparam int Q = 80;

  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end

  // Start or repeated start: data falls while clock high
  task automatic start();
    #Q m_oe = 1'b0;
    #Q scl = 1'b1;
    #(2 * Q) m_oe = 1'b1;
    #(2 * Q) scl = 1'b0;
  endtask

  // Stop: data rises while clock high, then bus free
  task automatic stop();
    #Q m_oe = 1'b1;
    #Q scl = 1'b1;
    #(2 * Q) m_oe = 1'b0;
    #(2 * Q);
  endtask

  // Clock pulse while low, narrower than the input filter window
  task automatic spike();
    #Q scl = 1'b1;
    #30 scl = 1'b0;
    #(Q - 30);
  endtask

  // One bit: data set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #Q m_oe = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask

  // Byte MSB first plus ninth bit; last=1 releases data for the ack
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, ack);
    ack = !ack;
  endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the temperature alarm sensor core
module tb_top import tsa_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int C = 600;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] adc_code = 12'h000;
  logic [1:0] evt_addr = 2'h0;
  logic [7:0] evt_wdata = 8'h00;
  logic evt_wr = 1'b0;
  logic evt_rd = 1'b0;
  logic [1:0] am = 2'h1;
  logic scl, m_oe, sda_out, sda_oe, alarm, evt_irq, add_in, a;
  logic [7:0] evt_rdata, q;
  logic [15:0] v;
  int fail_count = 0;
  int total_checks = 0;
  int fq[4] = '{1, 2, 4, 6};
  wire sda_w = !(m_oe | sda_oe);

  always #5 ref_clk = !ref_clk;
  // Address strap: low, high, to data or to clock
  assign add_in = am == 2'h0 ? 1'b0 : am == 2'h1 ? 1'b1 :
                  am == 2'h2 ? sda_w : scl;

  tsa_bus_master bm (.scl(scl), .m_oe(m_oe), .sda(sda_w));
  tsa_top #(.CONV_CYC(C)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .add_in(add_in),
    .overtemp_alarm_out(alarm), .adc_code(adc_code),
    .evt_addr(evt_addr), .evt_wdata(evt_wdata), .evt_wr(evt_wr),
    .evt_rd(evt_rd), .evt_rdata(evt_rdata), .evt_irq(evt_irq));

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic set_adc(input logic [11:0] c);
    @(posedge ref_clk);
    adc_code <= c;
  endtask

  // Event port write and read, data checked in the following cycle
  task automatic ew(input logic [1:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    evt_addr <= ad;
    evt_wdata <= d;
    evt_wr <= 1'b1;
    @(posedge ref_clk);
    evt_wr <= 1'b0;
  endtask

  task automatic er(input logic [1:0] ad, input logic [7:0] e);
    @(posedge ref_clk);
    evt_addr <= ad;
    evt_rd <= 1'b1;
    @(posedge ref_clk);
    evt_rd <= 1'b0;
    @(negedge ref_clk);
    ck({8'h00, evt_rdata}, {8'h00, e});
  endtask

  // Start and address byte, expecting an ack
  task automatic adr(input logic rw);
    bm.start();
    bm.xfer({DEV_ADDR_HI, am, rw}, 1'b1, q, a);
    ck(16'(a), 16'h0001);
  endtask

  task automatic wr(input logic [1:0] p, input int n, input logic [15:0] d);
    adr(1'b0);
    bm.xfer({6'h00, p}, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      bm.xfer(d[15 - 8 * i -: 8], 1'b1, q, a);
      ck(16'(a), 16'h0001);
    end
    bm.stop();
  endtask

  // Optional pointer write, then read n bytes, the last one not acked
  task automatic rd(input logic pw, input logic [1:0] p, input int n);
    v = 16'h0000;
    if (pw) begin
      adr(1'b0);
      bm.xfer({6'h00, p}, 1'b1, q, a);
    end
    adr(1'b1);
    for (int i = 0; i < n; i++) begin
      bm.xfer(8'hff, i == n - 1, q, a);
      v = {v[7:0], q};
    end
    bm.stop();
  endtask

  task automatic probe(input logic [6:0] ad, input logic e);
    bm.start();
    bm.xfer({ad, 1'b0}, 1'b1, q, a);
    ck(16'(a), 16'(e));
    bm.stop();
  endtask

  // Main sequence
  initial begin
    cyc(16);
    srst <= 1'b0;
    cyc(8);
    ck({14'h0, alarm, evt_irq}, 16'h0002);
    rd(1'b0, PTR_TEMP, 2);
    ck(v, TEMP_INVALID);
    wr(PTR_THIGH, 2, 16'h147f);
    wr(PTR_TLOW, 2, 16'h1200);
    rd(1'b1, PTR_THIGH, 2);
    ck(v, 16'h1400);
    // Every fault depth, polarity toggled alongside
    for (int d = 0; d < 4; d++) begin
      set_adc(12'h0a0);
      cyc(7 * C);
      wr(PTR_CFG, 1, {3'h0, d[1:0], d[0], 2'h0, 8'h00});
      set_adc(12'h320);
      cyc(fq[d] * C - C - 20);
      ck(16'(alarm), 16'(!d[0]));
      cyc(C + 60);
      ck(16'(alarm), 16'(d[0]));
    end
    // Interrupt mode: a register read clears the alarm
    set_adc(12'h0a0);
    cyc(7 * C);
    wr(PTR_CFG, 1, 16'h0200);
    set_adc(12'h320);
    cyc(2 * C);
    ck(16'(alarm), 16'h0000);
    rd(1'b1, PTR_CFG, 1);
    ck(v, 16'h0002);
    ck(16'(alarm), 16'h0001);
    // Comparator mode with hysteresis
    wr(PTR_CFG, 1, 16'h0000);
    cyc(2 * C);
    ck(16'(alarm), 16'h0000);
    rd(1'b1, PTR_TEMP, 2);
    ck(v, 16'h3200);
    set_adc(12'h130);
    cyc(3 * C);
    ck(16'(alarm), 16'h0000);
    set_adc(12'h0a0);
    cyc(3 * C);
    ck(16'(alarm), 16'h0001);
    // Shutdown, then event status, mask and interrupt
    wr(PTR_CFG, 1, 16'h0100);
    rd(1'b1, PTR_TEMP, 2);
    ck(v, TEMP_INVALID);
    ew(EVT_MASK_OFS, 8'h01);
    ew(EVT_STATUS_OFS, 8'h0f);
    cyc(3 * C);
    er(EVT_STATUS_OFS, 8'h00);
    ck(16'(evt_irq), 16'h0000);
    wr(PTR_CFG, 1, 16'h0000);
    cyc(2 * C);
    ck(16'(evt_irq), 16'h0001);
    er(EVT_STATUS_OFS, 8'h09);
    er(2'h2, 8'h00);
    ew(EVT_MASK_OFS, 8'h00);
    cyc(1);
    ck(16'(evt_irq), 16'h0000);
    // Every strap choice, each after a fresh reset since the strap is
    // decided once: own address acked, another ignored
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk);
      am <= m[1:0];
      srst <= 1'b1;
      cyc(16);
      srst <= 1'b0;
      cyc(8);
      bm.start();
      bm.stop();
      probe({DEV_ADDR_HI, m[1:0]}, 1'b1);
      probe({DEV_ADDR_HI, ~m[1:0]}, 1'b0);
    end
    // A clock pulse shorter than the filter window adds no bit
    bm.start();
    bm.spike();
    bm.xfer({DEV_ADDR_HI, am, 1'b0}, 1'b1, q, a);
    ck(16'(a), 16'h0001);
    bm.stop();
    close_out();
  end

  // Watchdog against a hung bus or handshake
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
endmodule
